/* logic/bist_ctrl_pkg.sv */
/*
  register map, field layout, reset values and helper functions for the
  buffer memory self-test controller.
  assumes a single 100 MHz system clock and a 32-bit AXI4-Lite master.
*/
`default_nettype none
package bist_ctrl_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEC_W = 4;

  localparam logic [DEC_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [DEC_W-1:0] OFF_SEED = 4'h4;
  localparam logic [DEC_W-1:0] OFF_END = 4'h8;
  localparam logic [DEC_W-1:0] OFF_ADDR = 4'hc;

  localparam int unsigned BIT_BUSY = 0;
  localparam int unsigned BIT_TME = 1;

  localparam logic [1:0] PAT_RANDOM = 2'h0;
  localparam logic [1:0] PAT_ADDRESS = 2'h1;
  localparam logic [1:0] PAT_SHIFT = 2'h2;
  localparam logic [1:0] PAT_RESERVED = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [DATA_W-1:0] SEED_RESET = 8'h01;
  localparam logic [ADDR_W-1:0] END_RESET = 13'h1fff;
  localparam logic [DATA_W-1:0] LFSR_TAPS = 8'hb8;

  // control byte minus the busy bit, msb first as it sits in the register
  typedef struct packed {
    logic [2:0] pattern_shift_amount;
    logic port_swap;
    logic [1:0] fill_pattern_selector;
    logic test_mode_enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_req_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_FILL = 1'b1
  } state_t;

  function automatic logic [DATA_W-1:0] rotl8(input logic [DATA_W-1:0] v,
                                              input logic [2:0] n);
    logic [2*DATA_W-1:0] wide;
    wide = {v, v} << n;
    return wide[2*DATA_W-1:DATA_W];
  endfunction

  function automatic logic [DATA_W-1:0] lfsr8(input logic [DATA_W-1:0] v);
    return {v[DATA_W-2:0], ^(v & LFSR_TAPS)};
  endfunction
endpackage
`default_nettype wire

/* logic/buffer_memory_self_test_control.sv */
/*
  buffer memory self-test controller: control register over AXI4-Lite,
  fill engine and the dma/self-test memory port swap.
  assumes the dma request arrives on aclk and the memory samples both
  ports on aclk; one write location per cycle while a test runs.
*/
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
// Functional notes
// [RQ1] port select one swaps dma and test ports
// [RQ2] selector: random, address, shifting fill; 11 reserved
// [RQ3] test mode enable puts memory in test
// [RQ4] busy reads one, hardware clears at end
// [RQ5] shifting fill shifts data by amount per location
// [RQ6] shift amount ignored unless selector is 10
// [RQ7] software enables test, then starts, then polls busy
`default_nettype none
module buffer_memory_self_test_control
  import bist_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire mem_req_t dma_req,
  output mem_req_t mem_port_a,
  output mem_req_t mem_port_b,
  output logic test_mode
);
  ctrl_t ctrl;
  state_t state;
  logic [DATA_W-1:0] seed;
  logic [DATA_W-1:0] fill;
  logic [ADDR_W-1:0] end_addr;
  logic [ADDR_W-1:0] bist_addr;

  // write channel: both address and data must be present before the
  // single-cycle ready pulse, so the two are taken on the same edge
  wire logic next_awready = awvalid & wvalid & ~awready & ~bvalid;
  wire logic wr_go = awready & awvalid & wvalid;
  wire logic [DEC_W-1:0] wr_idx = awaddr[DEC_W-1:0];
  wire logic wr_hi_zero = (awaddr[31:DEC_W] == '0);
  wire logic wr_ctrl = wr_go & wr_hi_zero & (wr_idx == OFF_CTRL);
  wire logic wr_seed = wr_go & wr_hi_zero & (wr_idx == OFF_SEED);
  wire logic wr_end = wr_go & wr_hi_zero & (wr_idx == OFF_END);
  wire logic wr_addr = wr_go & wr_hi_zero & (wr_idx == OFF_ADDR);
  wire logic wr_hit = wr_ctrl | wr_seed | wr_end | wr_addr;

  wire logic busy = (state == ST_FILL);
  wire ctrl_t wr_ctrl_val = wdata[DATA_W-1:1];
  // a start is taken only from idle and only with test mode set in the
  // same write, whatever the enable held before; writing zero to busy never aborts a test
  wire logic start_req = wr_ctrl & wstrb[0] & wdata[BIT_BUSY] & ~busy &
                         wr_ctrl_val.test_mode_enable;
  wire logic last_loc = busy & (bist_addr == end_addr);

  // fill data generation
  wire logic [1:0] pat = ctrl.fill_pattern_selector;
  wire logic pat_shift = (pat == PAT_SHIFT);
  wire logic pat_addr = (pat == PAT_ADDRESS);
  wire logic [DATA_W-1:0] shift_next = rotl8(fill, ctrl.pattern_shift_amount); // RQ5
  // RQ6: the shift amount only reaches the data path in shifting fill
  wire logic [DATA_W-1:0] next_fill = pat_shift ? shift_next : lfsr8(fill); // RQ2 RQ6
  wire logic [DATA_W-1:0] bist_data = pat_addr ? bist_addr[DATA_W-1:0] : fill; // RQ2
  wire mem_req_t bist_req = '{we: busy, addr: bist_addr, data: bist_data};

  // port steering, registered at the memory boundary
  wire logic swap = ctrl.port_swap;
  wire mem_req_t next_port_a = swap ? bist_req : dma_req; // RQ1
  wire mem_req_t next_port_b = swap ? dma_req : bist_req; // RQ1

  // read channel
  wire logic next_arready = arvalid & ~arready & ~rvalid;
  wire logic rd_go = arready & arvalid;
  wire logic [DEC_W-1:0] rd_idx = araddr[DEC_W-1:0];
  wire logic rd_hi_zero = (araddr[31:DEC_W] == '0);
  wire logic rd_ctrl = rd_hi_zero & (rd_idx == OFF_CTRL);
  wire logic rd_seed = rd_hi_zero & (rd_idx == OFF_SEED);
  wire logic rd_end = rd_hi_zero & (rd_idx == OFF_END);
  wire logic rd_addr = rd_hi_zero & (rd_idx == OFF_ADDR);
  wire logic rd_hit = rd_ctrl | rd_seed | rd_end | rd_addr;
  wire logic [31:0] ctrl_word = {24'h000000, ctrl, busy}; // RQ4
  wire logic [31:0] rd_word =
    rd_ctrl ? ctrl_word :
    rd_seed ? {24'h000000, seed} :
    rd_end ? {19'h00000, end_addr} :
    rd_addr ? {19'h00000, bist_addr} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= next_awready;
      wready <= next_awready;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= next_arready;
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // configuration registers; the current address register is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      seed <= SEED_RESET;
      end_addr <= END_RESET;
    end else begin
      if (wr_ctrl && wstrb[0]) begin
        ctrl <= wr_ctrl_val;
      end
      if (wr_seed && wstrb[0]) begin
        seed <= wdata[DATA_W-1:0];
      end
      // end address spans lanes 0 and 1; each lane updates on its own strobe
      if (wr_end && wstrb[0]) begin
        end_addr[DATA_W-1:0] <= wdata[DATA_W-1:0];
      end
      if (wr_end && wstrb[1]) begin
        end_addr[ADDR_W-1:DATA_W] <= wdata[ADDR_W-1:DATA_W];
      end
    end
  end

  // fill engine: one location per cycle from address zero to end_addr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      bist_addr <= '0;
      fill <= SEED_RESET;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            state <= ST_FILL; // RQ4
            bist_addr <= '0;
            fill <= seed;
          end
        end
        ST_FILL: begin
          fill <= next_fill; // RQ5
          if (last_loc) begin
            state <= ST_IDLE; // RQ4
          end else begin
            bist_addr <= bist_addr + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_port_a <= '0;
      mem_port_b <= '0;
      test_mode <= 1'b0;
    end else begin
      mem_port_a <= next_port_a;
      mem_port_b <= next_port_b;
      test_mode <= ctrl.test_mode_enable; // RQ3
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // the ports still show their reset value one edge after release, hence the guard
  chk_port_swap_steer: assert property ( // RQ1
    ##1 $past(aresetn) && $past(swap) |->
      (mem_port_a == $past(bist_req)) && (mem_port_b == $past(dma_req)))
    else $error("swapped ports do not carry the swapped requests");

  chk_port_normal_steer: assert property ( // RQ1
    ##1 $past(aresetn) && !$past(swap) |->
      (mem_port_a == $past(dma_req)) && (mem_port_b == $past(bist_req)))
    else $error("normal ports do not carry their own requests");

  chk_idle_port_b_quiet: assert property ( // RQ4
    !busy && !swap |=> !mem_port_b.we)
    else $error("self-test port writes while no test runs");

  chk_idle_port_a_quiet: assert property ( // RQ4
    !busy && swap |=> !mem_port_a.we)
    else $error("swapped self-test port writes while no test runs");

  chk_address_fill_data: assert property ( // RQ2
    busy && pat_addr && !swap |=>
      mem_port_b.we && (mem_port_b.addr == $past(bist_addr)) &&
      (mem_port_b.data == $past(bist_addr[DATA_W-1:0])))
    else $error("address fill writes data other than the address");

  chk_test_mode_follow: assert property ( // RQ3
    wr_ctrl && wstrb[0] |-> ##2 test_mode == $past(wr_ctrl_val.test_mode_enable, 2))
    else $error("test mode output does not follow the written enable");

  chk_test_mode_off: assert property ( // RQ3
    !ctrl.test_mode_enable |=> !test_mode)
    else $error("test mode output set while the enable is clear");

  chk_start_needs_enable: assert property ( // RQ3
    wr_ctrl && wstrb[0] && wdata[BIT_BUSY] &&
      !wr_ctrl_val.test_mode_enable && !busy |=> !busy)
    else $error("a start was taken with test mode disabled");

  chk_busy_start_addr: assert property ( // RQ4
    start_req |=> busy && (bist_addr == '0) && (fill == $past(seed)))
    else $error("busy flag not set at start or fill not at its first location");

  // every busy cycle but the last must advance one location, so a test ends within end_addr + 1 cycles
  chk_busy_hold_step: assert property ( // RQ4
    busy && !last_loc |=> busy && (bist_addr == $past(bist_addr) + 1'b1))
    else $error("busy dropped early or the fill address did not advance");

  chk_busy_auto_clear: assert property ( // RQ4
    last_loc |=> !busy && ctrl_word[BIT_BUSY] == 1'b0)
    else $error("busy flag not cleared after the last location");

  chk_busy_read_back: assert property ( // RQ4
    rd_go && rd_ctrl |=> rdata[BIT_BUSY] == $past(busy))
    else $error("control read does not show the busy flag");

  chk_shift_step_amount: assert property ( // RQ5
    busy && !last_loc && pat_shift && $stable(ctrl) |=>
      fill == rotl8($past(fill), $past(ctrl.pattern_shift_amount)))
    else $error("shifting fill did not advance by the shift amount");

  chk_shift_amount_ignored: assert property ( // RQ6
    busy && !last_loc && !pat_shift |=> fill == lfsr8($past(fill)))
    else $error("shift amount influenced a non-shifting fill");

  // a bus answer must stand until the master takes it
  chk_write_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before the master took it");

  chk_read_resp_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped before the master took it");

  chk_write_ready_pair: assert property (
    awready |-> wready ##1 (!awready && !wready))
    else $error("write address and data ready are not one shared pulse");

  chk_read_ready_pulse: assert property (
    arready |=> !arready)
    else $error("read address ready held for more than one cycle");

  chk_write_resp_code: assert property (
    wr_go && !wr_hit |=> bvalid && (bresp == RESP_SLVERR))
    else $error("unmapped write not answered with a slave error");

  chk_read_unmapped: assert property (
    rd_go && !rd_hit |=> rvalid && (rresp == RESP_SLVERR) && (rdata == '0))
    else $error("unmapped read not answered with zero data and a slave error");

  cov_test_started: cover property (start_req);
  cov_swapped_fill: cover property (busy && swap);
  cov_shift_fill_done: cover property (last_loc && pat_shift ##1 !busy);
  cov_unmapped_write: cover property (wr_go && !wr_hit);
  cov_address_fill: cover property (busy && pat_addr);
endmodule
`default_nettype wire

/* testbench/test_buffer_memory_self_test_control.sv */
/*
  self-checking bench for the buffer memory self-test controller: registers
  over axi4-lite, port swap, test mode, all four fill selectors, busy clearing.
  assumes the package and the design module compiled ahead of this file.
*/
`default_nettype none
module test_buffer_memory_self_test_control
  import bist_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, test_mode;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  mem_req_t dma_req, mem_port_a, mem_port_b;
  mem_req_t cap[$];
  mem_req_t capa[$];
  int n_mismatch = 0;
  int n_tests = 0;

  buffer_memory_self_test_control buffer_memory_self_test_control_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .dma_req(dma_req), .mem_port_a(mem_port_a), .mem_port_b(mem_port_b),
    .test_mode(test_mode));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // writes as the registered ports show them; port a keeps only what differs from dma
  always @(posedge aclk) begin
    if (mem_port_b.we === 1'b1) cap.push_back(mem_port_b);
    if (mem_port_a.we === 1'b1 && mem_port_a !== dma_req) capa.push_back(mem_port_a);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic reg_map();
    logic [31:0] d;
    logic [1:0] r;
    rd(32'h0, d, r);
    check("ctrl reset", d, 32'h0);
    rd(32'h4, d, r);
    check("seed reset", d, 32'h1);
    rd(32'h8, d, r);
    check("end reset", d, 32'h1fff);
    rd(32'h10, d, r);
    check("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(32'h6, 32'hff, r);
    check("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("test mode idle", {31'h0, test_mode}, 32'h0);
  endtask

  task automatic swap_and_mode();
    logic [1:0] r;
    wr(32'h0, 32'h12, r);
    repeat (2) @(posedge aclk);
    #1;
    check("swapped port b", {10'h0, mem_port_b}, {10'h0, dma_req});
    check("test mode on", {31'h0, test_mode}, 32'h1);
    wr(32'h0, 32'h00, r);
    repeat (2) @(posedge aclk);
    #1;
    check("normal port a", {10'h0, mem_port_a}, {10'h0, dma_req});
    check("test mode off", {31'h0, test_mode}, 32'h0);
  endtask

  // a start with test mode clear must leave the engine idle
  task automatic start_refused();
    logic [31:0] d;
    logic [1:0] r;
    cap.delete();
    wr(32'h0, 32'h01, r);
    rd(32'h0, d, r);
    check("start without enable", d, 32'h0);
    check("no self-test writes", cap.size(), 32'd0);
  endtask

  // address fill with the ports swapped: self-test writes leave by port a
  task automatic swap_fill();
    logic [31:0] d;
    logic [1:0] r;
    cap.delete();
    capa.delete();
    wr(32'h0, 32'h17, r);
    do rd(32'h0, d, r); while (d[0] !== 1'b0);
    check("swapped write count", capa.size(), 32'd16);
    check("dma on port b", {10'h0, cap[0]}, {10'h0, dma_req});
    for (int i = 0; i < capa.size(); i++) begin
      check("swapped fill addr", {19'h0, capa[i].addr}, i);
      check("swapped fill data", {24'h0, capa[i].data}, i);
    end
    wr(32'h0, 32'h00, r);
  endtask

  // shift amount 3 with every selector: only 10 may rotate the fill
  task automatic fill(input logic [1:0] pat);
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] f;
    logic [7:0] e;
    f = 8'h81;
    cap.delete();
    wr(32'h0, {24'h0, 3'h3, 1'b0, pat, 2'b11}, r);
    rd(32'h0, d, r);
    check("busy during test", {31'h0, d[0]}, 32'h1);
    do rd(32'h0, d, r); while (d[0] !== 1'b0);
    check("write count", cap.size(), 32'd16);
    for (int i = 0; i < cap.size(); i++) begin
      e = (pat == PAT_ADDRESS) ? 8'(i) : f;
      check("fill addr", {19'h0, cap[i].addr}, i);
      check("fill data", {24'h0, cap[i].data}, {24'h0, e});
      if (pat == PAT_SHIFT) f = {f[4:0], f[7:5]};
      else f = {f[6:0], ^(f & LFSR_TAPS)};
    end
  endtask

  initial begin
    logic [1:0] r;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    dma_req = '{we: 1'b1, addr: 13'h0a5c, data: 8'h3c};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reg_map();
    start_refused();
    swap_and_mode();
    wr(32'h4, 32'h81, r);
    wr(32'h8, 32'h000f, r);
    for (int p = 0; p < 4; p++) fill(2'(p));
    swap_fill();
    close_out();
  end

  // a full run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
